// [hdl/pin_sync.sv]
// three-stage input synchroniser with agreement filter
module pin_sync
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);

	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// the output moves only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= 1'b0;
		else if (s2 == s3)
			q <= s3;
	end

endmodule : pin_sync

// [hdl/standby_ctrl.sv]
// standby power-mode controller with auto power-down timer, APB slave
//
// How it works
// - standby command enters standby, loads timeout
// - standby keeps spindle stopped, interface alive
// - already stopped spindle skips spin-down
// - non-standby commands accepted in standby wait spin-up
// - timer counts only while idle
// - zero timeout disables the timer
// - codes 1-240 five seconds, 241-251 half-hours
// - codes 252 to 255 special intervals
// - timer expiry enters standby on its own
// - any host access reloads full interval
// - immediate standby enters standby the same way
// - immediate standby keeps the timeout code
module standby_ctrl
#(
	parameter int unsigned TICK_CYCLES       = standby_pkg::TICK_CYCLES,
	parameter int unsigned SPIN_LIMIT_CYCLES = standby_pkg::SPIN_LIMIT_CYCLES
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        spindle_stopped,
	input  wire logic        spindle_at_speed,
	output logic             spindle_run,
	output logic             standby_mode,
	output logic             command_done
);

	// ======================================================
	// pin synchronisers
	logic stopped_s;
	logic at_speed_s;

	pin_sync stopped_sync
	(
		.clk   (pclk),
		.rst_n (presetn),
		.d     (spindle_stopped),
		.q     (stopped_s)
	);

	pin_sync speed_sync
	(
		.clk   (pclk),
		.rst_n (presetn),
		.d     (spindle_at_speed),
		.q     (at_speed_s)
	);

	// ======================================================
	// state
	standby_pkg::power_state_t state;
	standby_pkg::power_state_t next_state;

	logic                            busy;
	logic                            abort_flag;
	logic [7:0]                      timeout_code;
	logic [standby_pkg::UNITS_W-1:0] timeout_units;
	logic [standby_pkg::UNITS_W-1:0] remain;
	logic [31:0]                     prescale;
	logic [31:0]                     spin_wd;
	logic                            finish;
	logic                            fail;
	logic                            timer_active;
	logic                            timer_expired;
	logic                            wd_expired;

	// ======================================================
	// APB decode
	logic       apb_setup;
	logic       apb_access;
	logic       cmd_write;
	logic       cmd_accept;
	logic       cmd_refused;
	logic       addr_hit;
	logic [7:0] opcode;
	logic [7:0] count;
	logic       is_standby;
	logic       is_immed;
	logic       is_sleepy;

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign cmd_write  = apb_access & pwrite
		& (paddr == standby_pkg::OFF_COMMAND);
	assign opcode     = pwdata[standby_pkg::OPCODE_LSB +: 8];
	assign count      = pwdata[standby_pkg::COUNT_LSB +: 8];

	assign is_standby = (opcode == standby_pkg::OP_STANDBY_A)
		| (opcode == standby_pkg::OP_STANDBY_B);
	assign is_immed   = (opcode == standby_pkg::OP_IMMED_A)
		| (opcode == standby_pkg::OP_IMMED_B);
	assign is_sleepy  = is_standby | is_immed;

	// a new command is taken only when none runs and the spindle is not
	// in the middle of an automatic spin-down or a spin-up
	assign cmd_accept  = cmd_write & ~busy
		& ((state == standby_pkg::PS_IDLE)
		| (state == standby_pkg::PS_STANDBY));
	assign cmd_refused = cmd_write & ~cmd_accept;

	always_comb
	begin
		case (paddr)
			standby_pkg::OFF_COMMAND,
			standby_pkg::OFF_STATUS,
			standby_pkg::OFF_ERROR,
			standby_pkg::OFF_POWER,
			standby_pkg::OFF_TIMER:
				addr_hit = 1'b1;
			default:
				addr_hit = 1'b0;
		endcase
	end

	// zero wait states; the error answer is valid with pready
	assign pready  = apb_access;
	assign pslverr = apb_access & (~addr_hit | cmd_refused);

	// ======================================================
	// timeout decode
	timeout_decode decoder
	(
		.code  (timeout_code),
		.units (timeout_units)
	);

	// ======================================================
	// power-mode state machine
	always_comb
	begin
		next_state = state;
		finish     = 1'b0;
		fail       = 1'b0;
		case (state)
			standby_pkg::PS_IDLE:
			begin
				if (cmd_accept && is_sleepy)
				begin
					// no spin-down sequence when already stopped
					if (stopped_s)
					begin
						next_state = standby_pkg::PS_STANDBY;
						finish     = 1'b1;
					end
					else
						next_state = standby_pkg::PS_SPIN_DOWN;
				end
				else if (cmd_accept)
					finish = 1'b1;
				// interval ran out without host access
				else if (timer_expired)
					next_state = standby_pkg::PS_SPIN_DOWN;
			end
			standby_pkg::PS_SPIN_DOWN:
			begin
				if (stopped_s)
				begin
					next_state = standby_pkg::PS_STANDBY;
					finish     = busy;
				end
				// spindle would not stop in time
				else if (wd_expired)
				begin
					next_state = standby_pkg::PS_IDLE;
					finish     = busy;
					fail       = busy;
				end
			end
			standby_pkg::PS_STANDBY:
			begin
				// other commands first bring the spindle back
				if (cmd_accept && is_sleepy)
					finish = 1'b1;
				else if (cmd_accept)
					next_state = standby_pkg::PS_SPIN_UP;
			end
			standby_pkg::PS_SPIN_UP:
			begin
				if (at_speed_s)
				begin
					next_state = standby_pkg::PS_IDLE;
					finish     = busy;
				end
			end
			default:
				next_state = standby_pkg::PS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= standby_pkg::PS_IDLE;
		else
			state <= next_state;
	end

	// spindle held stopped in spin-down and standby
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			spindle_run <= 1'b1;
		else
			spindle_run <= (next_state == standby_pkg::PS_IDLE)
				| (next_state == standby_pkg::PS_SPIN_UP);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			standby_mode <= 1'b0;
		else
			standby_mode <= (next_state == standby_pkg::PS_STANDBY);
	end

	// ======================================================
	// command busy and completion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy <= 1'b0;
		else if (finish)
			busy <= 1'b0;
		else if (cmd_accept)
			busy <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			command_done <= 1'b0;
		else
			command_done <= finish;
	end

	// abort flag set on failure, cleared by the next command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			abort_flag <= 1'b0;
		else if (fail)
			abort_flag <= 1'b1;
		else if (cmd_accept)
			abort_flag <= 1'b0;
	end

	// ======================================================
	// timeout parameter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timeout_code <= standby_pkg::TIMEOUT_CODE_RESET;
		// only the standby opcodes load the code
		else if (cmd_accept && is_standby)
			timeout_code <= count;
	end

	// ======================================================
	// spin-down watchdog
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			spin_wd <= 32'h0000_0000;
		else if (state != standby_pkg::PS_SPIN_DOWN)
			spin_wd <= 32'h0000_0000;
		else if (!wd_expired)
			spin_wd <= spin_wd + 32'h0000_0001;
	end

	assign wd_expired = (spin_wd == 32'(SPIN_LIMIT_CYCLES - 1));

	// ======================================================
	// auto power-down timer
	// counts only in idle
	assign timer_active = (state == standby_pkg::PS_IDLE)
		& (timeout_units != '0);

	// host access in the same cycle wins over expiry
	assign timer_expired = timer_active & ~apb_access
		& (remain == standby_pkg::UNITS_W'(1))
		& (prescale == 32'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= 32'h0000_0000;
			remain   <= '0;
		end
		// any access reloads the full interval
		else if (apb_access || !timer_active)
		begin
			prescale <= 32'h0000_0000;
			remain   <= timeout_units;
		end
		else if (prescale == 32'(TICK_CYCLES - 1))
		begin
			prescale <= 32'h0000_0000;
			remain   <= remain - standby_pkg::UNITS_W'(1);
		end
		else
			prescale <= prescale + 32'h0000_0001;
	end

	// ======================================================
	// read data, loaded in the setup cycle
	logic [7:0]  status_flags;
	logic [7:0]  error_flags;
	logic [31:0] power_word;

	always_comb
	begin
		status_flags = 8'h00;
		status_flags[standby_pkg::ST_BSY] = busy;
		status_flags[standby_pkg::ST_RDY] = 1'b1;
		status_flags[standby_pkg::ST_DSC] = ~busy;
		// error bit follows the abort flag
		status_flags[standby_pkg::ST_ERR] = abort_flag;
		error_flags = 8'h00;
		error_flags[standby_pkg::ERR_ABT] = abort_flag;
		power_word = 32'h0000_0000;
		power_word[standby_pkg::PWR_STATE_LSB +: 2] = state;
		power_word[standby_pkg::PWR_RUN_BIT] = spindle_run;
		power_word[standby_pkg::PWR_ACT_BIT] = timer_active;
		power_word[standby_pkg::PWR_CODE_LSB +: 8] = timeout_code;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (apb_setup)
		begin
			case (paddr)
				standby_pkg::OFF_STATUS:
					prdata <= {24'h000000, status_flags};
				standby_pkg::OFF_ERROR:
					prdata <= {24'h000000, error_flags};
				standby_pkg::OFF_POWER:
					prdata <= power_word;
				standby_pkg::OFF_TIMER:
					prdata <= {19'h00000, remain};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : standby_ctrl

// [hdl/standby_pkg.sv]
// constants and types for the standby power-mode controller
package standby_pkg;

	// ======================================================
	// clock and timing
	localparam int unsigned CLK_HZ             = 100_000_000;
	localparam int unsigned TICK_SECONDS       = 5;
	localparam int unsigned TICK_CYCLES        = CLK_HZ * TICK_SECONDS;
	localparam int unsigned SPIN_LIMIT_SECONDS = 20;
	localparam int unsigned SPIN_LIMIT_CYCLES  = CLK_HZ * SPIN_LIMIT_SECONDS;

	// ======================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_ERROR   = 8'h08;
	localparam logic [7:0] OFF_POWER   = 8'h0C;
	localparam logic [7:0] OFF_TIMER   = 8'h10;

	// command register fields
	localparam int OPCODE_LSB = 0;
	localparam int COUNT_LSB  = 8;

	// power register fields
	localparam int PWR_STATE_LSB = 0;
	localparam int PWR_RUN_BIT   = 4;
	localparam int PWR_ACT_BIT   = 5;
	localparam int PWR_CODE_LSB  = 8;

	// ======================================================
	// opcodes
	localparam logic [7:0] OP_STANDBY_A = 8'hE2;
	localparam logic [7:0] OP_STANDBY_B = 8'h96;
	localparam logic [7:0] OP_IMMED_A   = 8'hE0;
	localparam logic [7:0] OP_IMMED_B   = 8'h94;

	// ======================================================
	// status and error bit positions
	localparam int ST_BSY  = 7;
	localparam int ST_RDY  = 6;
	localparam int ST_DSC  = 4;
	localparam int ST_ERR  = 0;
	localparam int ERR_ABT = 2;

	// ======================================================
	// timeout codes, decoded into 5 s units
	localparam int UNITS_W = 13;
	localparam logic [7:0] CODE_SHORT_MAX = 8'hF0;
	localparam logic [7:0] CODE_LONG_MAX  = 8'hFB;
	localparam logic [7:0] CODE_8_HOURS   = 8'hFD;
	localparam logic [UNITS_W-1:0] UNITS_HALF_HOUR = 13'h0168;
	localparam logic [UNITS_W-1:0] UNITS_8_HOURS   = 13'h1680;

	// ======================================================
	// reset values
	localparam logic [7:0] TIMEOUT_CODE_RESET = 8'h00;

	typedef enum logic [1:0]
	{
		PS_IDLE      = 2'h0,
		PS_SPIN_DOWN = 2'h1,
		PS_STANDBY   = 2'h2,
		PS_SPIN_UP   = 2'h3
	} power_state_t;

endpackage : standby_pkg

// [hdl/timeout_decode.sv]
// decodes the timeout code into a count of 5 s units
module timeout_decode
(
	input  wire logic [7:0]                     code,
	output logic [standby_pkg::UNITS_W-1:0]     units
);

	logic [standby_pkg::UNITS_W-1:0] half_hours;
	logic [standby_pkg::UNITS_W-1:0] wide_code;

	assign wide_code  = {5'h00, code};
	assign half_hours = standby_pkg::UNITS_W'(wide_code
		- standby_pkg::UNITS_W'(standby_pkg::CODE_SHORT_MAX));

	always_comb
	begin
		if (code <= standby_pkg::CODE_SHORT_MAX)
			units = wide_code;
		else if (code <= standby_pkg::CODE_LONG_MAX)
			units = standby_pkg::UNITS_W'(half_hours
				* standby_pkg::UNITS_HALF_HOUR);
		// special codes; 252, 254, 255 equal their own unit count
		else if (code == standby_pkg::CODE_8_HOURS)
			units = standby_pkg::UNITS_8_HOURS;
		else
			units = wide_code;
	end

endmodule : timeout_decode

// [test/spindle_model.sv]
// behavioural spindle: ramps speed while driven, coasts down when not
module spindle_model
#(
	parameter int SPIN_CYC = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic spindle_run,
	input wire logic stuck,
	output logic     spindle_stopped,
	output logic     spindle_at_speed
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================
	// speed ramp; stuck models a spindle that never comes to rest
	int level;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			level <= SPIN_CYC;
		else if (spindle_run && level < SPIN_CYC)
			level <= level + 1;
		else if (!spindle_run && !stuck && level > 0)
			level <= level - 1;
	assign spindle_stopped = (level == 0);
	assign spindle_at_speed = (level == SPIN_CYC);
endmodule : spindle_model

// [test/standby_ctrl_sva.sv]
// port assertions for the standby controller
module standby_ctrl_sva
#(
	parameter int unsigned TICK_CYCLES       = 4,
	parameter int unsigned SPIN_LIMIT_CYCLES = 50
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        spindle_stopped,
	input wire logic        spindle_at_speed,
	input wire logic        spindle_run,
	input wire logic        standby_mode,
	input wire logic        command_done
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================
	// helpers
	// bound covers the spin-down limit the bench sets plus sync delay
	localparam int DONE_MAX = 70;
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stby_ok;
		acc && pwrite && !pslverr && paddr == standby_pkg::OFF_COMMAND
		&& pwdata[7:0] inside {8'hE2, 8'h96, 8'hE0, 8'h94};
	endsequence

	property p_ready_now; acc |-> pready; endproperty
	a_ready_now: assert property (p_ready_now)
		else $error("no zero-wait answer");
	property p_ready_idle; !acc |-> !pready && !pslverr; endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("answer outside access");
	property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_status;
		acc && !pwrite && paddr == standby_pkg::OFF_STATUS |->
		prdata[6] && prdata[4] == !prdata[7];
	endproperty
	a_status: assert property (p_status)
		else $error("status ready bits wrong");
	property p_stby_stop; s_stby_ok |=> !spindle_run; endproperty
	a_stby_stop: assert property (p_stby_stop)
		else $error("spindle kept running");
	property p_stby_done; s_stby_ok |-> ##[1:DONE_MAX] command_done;
	endproperty
	a_stby_done: assert property (p_stby_done)
		else $error("standby never completed");
	property p_done_pulse; command_done |=> !command_done; endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than a pulse");
	property p_stby_quiet;
		standby_mode && $past(standby_mode) |-> !$past(spindle_run);
	endproperty
	a_stby_quiet: assert property (p_stby_quiet)
		else $error("spindle driven in standby");
endmodule : standby_ctrl_sva

// [test/test_standby_power_mode_control.sv]
// self-checking bench for the standby controller
module test_standby_power_mode_control;
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================
	// shortened counts keep the run short
	localparam int unsigned TICK = 4;
	localparam int unsigned LIMIT = 50;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic stuck = 0, err, pready, pslverr, stopped, at_speed;
	logic spindle_run, standby_mode, command_done;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int bad_count = 0, cmp_count = 0, cycles = 0, n;
	logic [7:0] codes[8] = '{8'h01, 8'hF0, 8'hF1, 8'hFB,
		8'hFC, 8'hFD, 8'hFE, 8'hFF};
	int units[8] = '{1, 240, 360, 3960, 252, 5760, 254, 255};

	always #5 pclk = ~pclk;

	standby_ctrl #(.TICK_CYCLES(TICK), .SPIN_LIMIT_CYCLES(LIMIT)) DUT
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.spindle_stopped(stopped), .spindle_at_speed(at_speed),
		.spindle_run(spindle_run), .standby_mode(standby_mode),
		.command_done(command_done)
	);
	spindle_model #(.SPIN_CYC(8)) spindle
	(
		.pclk(pclk), .presetn(presetn), .spindle_run(spindle_run),
		.stuck(stuck), .spindle_stopped(stopped),
		.spindle_at_speed(at_speed)
	);

	// ======================================================
	// tasks
	task end_of_test;
		$display("mismatches %0d, compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s: %h not %h", $time, s, got, exp);
		end
	endtask : chk

	task chk_span(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			bad_count++;
			$display("[FAIL] %0t expiry after %0d not %0d", $time, got, lo);
		end
	endtask : chk_span

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task cmd(input logic [7:0] op, input logic [7:0] cnt);
		apb(1'b1, standby_pkg::OFF_COMMAND, {16'h0, cnt, op});
	endtask : cmd

	// the pulse of a command that completes at once starts at the access
	// edge itself, so look just after that edge before stepping on
	task wait_done;
		n = 0;
		#1;
		while (command_done !== 1'b1 && n < 300)
		begin
			@(posedge pclk);
			#1 n++;
		end
		chk(32'(command_done), 32'h1, "done");
	endtask : wait_done

	task rd_chk(input logic [7:0] a, input logic [15:0] exp);
		apb(1'b0, a, 32'h0);
		chk(32'(rd[15:0]), 32'(exp), "read");
	endtask : rd_chk

	// ======================================================
	// hang guard
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			bad_count++;
			$display("[FAIL] %0t timeout", $time);
			end_of_test();
		end
	end

	// ======================================================
	// main sequence
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(standby_pkg::OFF_POWER, 16'h0010);
		rd_chk(standby_pkg::OFF_STATUS, 16'h0050);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(err), 32'h1, "unmapped");
		cmd(standby_pkg::OP_STANDBY_A, 8'h03);
		cmd(standby_pkg::OP_IMMED_A, 8'h00);
		chk(32'(err), 32'h1, "busy refusal");
		wait_done();
		rd_chk(standby_pkg::OFF_POWER, 16'h0302);
		foreach (codes[i])
			if (i < 2)
			begin
				cmd(i ? standby_pkg::OP_IMMED_B : standby_pkg::OP_IMMED_A, 8'hFF);
				wait_done();
				rd_chk(standby_pkg::OFF_POWER, 16'h0302);
			end
		cmd(8'h20, 8'h00);
		wait_done();
		rd_chk(standby_pkg::OFF_POWER, 16'h0330);
		rd_chk(standby_pkg::OFF_TIMER, 16'h0003);
		repeat (5)
		begin
			repeat (6) @(posedge pclk);
			apb(1'b0, standby_pkg::OFF_STATUS, 32'h0);
		end
		chk(32'(standby_mode), 32'h0, "reload");
		repeat (40) @(posedge pclk);
		chk(32'(standby_mode), 32'h1, "auto");
		foreach (codes[i])
		begin
			cmd(i % 2 ? 8'h96 : 8'hE2, codes[i]);
			wait_done();
			cmd(8'h20, 8'h00);
			wait_done();
			apb(1'b0, standby_pkg::OFF_POWER, 32'h0);
			n = 0;
			while (spindle_run === 1'b1 && n < 30000)
			begin
				@(posedge pclk);
				#1 n++;
			end
			chk_span(n, units[i] * TICK - 1, units[i] * TICK + 2);
			while (standby_mode !== 1'b1)
				@(posedge pclk);
		end
		cmd(standby_pkg::OP_STANDBY_A, 8'h00);
		wait_done();
		cmd(8'h20, 8'h00);
		wait_done();
		repeat (200) @(posedge pclk);
		chk(32'(spindle_run), 32'h1, "timer off");
		stuck <= 1'b1;
		cmd(standby_pkg::OP_STANDBY_B, 8'h00);
		wait_done();
		rd_chk(standby_pkg::OFF_ERROR, 16'h0004);
		rd_chk(standby_pkg::OFF_STATUS, 16'h0051);
		stuck <= 1'b0;
		cmd(standby_pkg::OP_IMMED_B, 8'h00);
		wait_done();
		rd_chk(standby_pkg::OFF_ERROR, 16'h0000);
		end_of_test();
	end
endmodule : test_standby_power_mode_control

bind standby_ctrl standby_ctrl_sva
#(.TICK_CYCLES(TICK_CYCLES), .SPIN_LIMIT_CYCLES(SPIN_LIMIT_CYCLES)) sva
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .spindle_stopped(spindle_stopped),
	.spindle_at_speed(spindle_at_speed), .spindle_run(spindle_run),
	.standby_mode(standby_mode), .command_done(command_done)
);
